/* embcc_ctrl.sv */
// Bus-state logic for SRAM-style external areas with register slave
`timescale 1ns/10ps
// Notes on behaviour
// - SRAM space: area0 modes 000/001, area1 no DRAM, 2-4, 5 high, 6 high or no mux I/O, 7 low
// - A basic external cycle lasts one or two states, chosen by wait bits
// - Read strobe high 35% of first state with duty bit set, else 50%
// - First wait register governs CPU and dual reads; second governs single-mode
// - Short areas with clear wait bit finish in one state, pin ignored
// - Short areas with wait bit set take two states plus pin waits
// - Pin sampled at edge before second state; low inserts waits, high ends
// - Long areas with clear wait bit: one state plus 1 to 4 long waits
// - Long areas with wait bit: pin sampled before last long wait, adds waits
// - CPU and dual writes in short areas always sample pin, two states minimum
// - CPU and dual writes in long areas: one plus long waits plus pin waits
// - 16-bit space: clear select gives hi/lo store and A0; set gives selects
// - Both byte schemes work for multiplexed I/O and external memory
// - 8-bit space: A0 stays address, lo store pin is strobe, hi unused
// - DRAM enable turns area 1 into DRAM space, no SRAM-style strobes
// - Address mux enable time-shares row and column on address pins
// - Shift 00 drives bits 23-8 on pins 15-0 as row; column unshifted
// - Long-wait count comes from two fields, areas 0/2 and area 6
module embcc_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  input wire embcc_pkg::embcc_req_t req,
  output logic req_ack,
  output logic req_err,
  input wire logic [2:0] mode_select_pins,
  input wire logic wait_n_pin,
  output embcc_pkg::embcc_pins_t pins
);
  import embcc_pkg::*;

  embcc_state_t state_ff;
  logic [15:0] bus_control_reg_ff, wait_control_first_ff, wait_control_second_ff;
  logic [15:0] wait_control_third_ff, dram_ctrl_reg_ff;
  logic [31:0] readdata_ff;
  logic waitreq_ff;
  logic ack_ff, err_ff;
  embcc_pins_t pins_ff, nxt_pins;
  logic [4:0] tick_ff;
  logic [2:0] left_ff, nxt_left, lw_cnt;
  logic first_ff;
  logic [2:0] area_ff;
  logic [23:0] addr_ff;
  logic wr_ff, bus16_ff, dram_ff, pin_en_ff, nxt_pin_en, gov_bit;
  logic [1:0] be_ff;
  logic [3:0] sync_w;
  logic wait_s;
  logic [2:0] mode_s;
  logic [2:0] area_dec;
  logic space_ok, dram_hit, start, end_state, fin, hold_wait;
  logic [21:0] mux_addr;
  logic [3:0] st_cnt_ff, waits_ff;
  logic [2:0] total_ff;

  // Decoders for the start logic and the assertions, and the byte merge used by register writes
  function automatic logic is_sram_space(input logic [2:0] area, input logic a27,
                                         input logic [2:0] md, input logic dram,
                                         input logic mux_io);
    unique case (area)
      3'h0: return (md == MODE_EXT8) || (md == MODE_EXT16);
      3'h1: return !dram;
      3'h5: return a27;
      3'h6: return !mux_io || a27;
      3'h7: return !a27;
      default: return 1'b1;
    endcase
  endfunction

  function automatic logic is_bus16(input logic [2:0] area, input logic a27,
                                    input logic a14, input logic [2:0] md);
    unique case (area)
      3'h0: return md == MODE_EXT16;
      3'h5: return 1'b1;
      3'h6: return a27 || a14;
      3'h7: return 1'b0;
      default: return a27;
    endcase
  endfunction

  function automatic logic is_long_area(input logic [2:0] area);
    return (area == 3'h0) || (area == 3'h2) || (area == 3'h6);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Wait and mode pins arrive from outside the clock domain
  embcc_sync2 #(.W(4)) embcc_sync2_inst (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({wait_n_pin, mode_select_pins}),
    .sync_out(sync_w)
  );
  assign wait_s = sync_w[3];
  assign mode_s = sync_w[2:0];

  embcc_addr_mux embcc_addr_mux_inst (
    .addr(addr_ff),
    .mux_en(dram_ff && dram_ctrl_reg_ff[DRAMCTL_MUX_EN]),
    .shift(dram_ctrl_reg_ff[DRAMCTL_SHIFT_LSB +: 2]),
    .row_phase(first_ff),
    .pin_addr(mux_addr)
  );

  // Cycle set-up decode
  always_comb begin
    area_dec = req.addr[26:24];
    dram_hit = (area_dec == 3'h1) && bus_control_reg_ff[BUSCTL_DRAM_EN];
    // external space decode; multiplexed I/O in area 6 is run as well
    space_ok = dram_hit || (area_dec == 3'h6) ||
               is_sram_space(area_dec, req.addr[27], mode_s,
                             bus_control_reg_ff[BUSCTL_DRAM_EN],
                             bus_control_reg_ff[BUSCTL_MUX_IO]);
    lw_cnt = (area_dec == 3'h6) ? {1'b0, wait_control_third_ff[WAIT3_SIX_LSB +: 2]}
                                : {1'b0, wait_control_third_ff[WAIT3_LOW_LSB +: 2]};
    lw_cnt = lw_cnt + 3'h1;
    gov_bit = (req.kind == KIND_DMA_SINGLE) ? wait_control_second_ff[WAIT_READ_LSB + area_dec]
                                            : wait_control_first_ff[WAIT_READ_LSB + area_dec];
    nxt_pin_en = (req.write && (req.kind != KIND_DMA_SINGLE)) ? 1'b1 : gov_bit;
    if (dram_hit) begin
      nxt_pin_en = 1'b0;
      nxt_left = dram_ctrl_reg_ff[DRAMCTL_MUX_EN] ? 3'h2 : 3'h1;
    end else if (is_long_area(area_dec)) begin
      nxt_left = lw_cnt + 3'h1;
    end else begin
      nxt_left = nxt_pin_en ? 3'h2 : 3'h1;
    end
  end

  assign start = (state_ff == ST_IDLE) && req_valid;
  assign end_state = (state_ff == ST_RUN) && (tick_ff == TICK_LAST);
  assign fin = end_state && (left_ff == 3'h1);
  // pin low at the sampling edge holds the cycle
  assign hold_wait = pin_en_ff && (left_ff == 3'h2) && !wait_s;

  // Cycle sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else if (clk_en) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (req_valid) begin
            state_ff <= space_ok ? ST_RUN : ST_DONE;
          end
        end
        ST_RUN: begin
          if (fin) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
      endcase
    end
  end

  // State ticks and states left; a held wait state repeats the sampling state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_ff <= 5'h00;
      left_ff <= 3'h0;
      first_ff <= 1'b0;
    end else if (clk_en) begin
      if (start && space_ok) begin
        tick_ff <= 5'h00;
        left_ff <= nxt_left;
        first_ff <= 1'b1;
      end else if (state_ff == ST_RUN) begin
        if (end_state) begin
          tick_ff <= 5'h00;
          first_ff <= 1'b0;
          if (!hold_wait) begin
            left_ff <= left_ff - 3'h1;
          end
        end else begin
          tick_ff <= tick_ff + 5'h01;
        end
      end
    end
  end

  // Latched cycle attributes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      area_ff <= 3'h0;
      addr_ff <= 24'h000000;
      wr_ff <= 1'b0;
      be_ff <= 2'h0;
      bus16_ff <= 1'b0;
      dram_ff <= 1'b0;
      pin_en_ff <= 1'b0;
    end else if (clk_en && start && space_ok) begin
      area_ff <= area_dec;
      addr_ff <= req.addr[23:0];
      wr_ff <= req.write;
      be_ff <= req.be;
      bus16_ff <= is_bus16(area_dec, req.addr[27], req.addr[14], mode_s);
      dram_ff <= dram_hit;
      pin_en_ff <= nxt_pin_en;
    end
  end

  // Handshake back to the CPU or DMA side
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= fin || (start && !space_ok);
      err_ff <= start && !space_ok;
    end
  end

  // Pin values; registered so every pin leaves a flop
  always_comb begin
    nxt_pins = PINS_IDLE;
    nxt_pins.addr = pins_ff.addr;
    if (state_ff == ST_RUN) begin
      nxt_pins.addr = mux_addr;
      if (!dram_ff) begin
        nxt_pins.cs_n[area_ff] = 1'b0;
        if (!wr_ff) begin
          nxt_pins.rd_n = first_ff && (tick_ff < (bus_control_reg_ff[BUSCTL_RD_DUTY] ?
                                                  DUTY35_TICKS : DUTY50_TICKS));
        end
        if (bus16_ff && bus_control_reg_ff[BUSCTL_BYTE_SEL]) begin
          nxt_pins.lo_store_n = !wr_ff;
          nxt_pins.hi_store_n = !be_ff[0];
          nxt_pins.a0_upper = !be_ff[1];
        end else if (bus16_ff) begin
          nxt_pins.hi_store_n = !(wr_ff && be_ff[1]);
          nxt_pins.lo_store_n = !(wr_ff && be_ff[0]);
          nxt_pins.a0_upper = addr_ff[0];
        end else begin
          nxt_pins.lo_store_n = !wr_ff;
          nxt_pins.a0_upper = addr_ff[0];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pins_ff <= PINS_IDLE;
    end else if (clk_en) begin
      pins_ff <= nxt_pins;
    end
  end

  // Avalon slave: one wait cycle, write lands when waitrequest is seen low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      waitreq_ff <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      if (waitreq_ff && (avs_read || avs_write)) begin
        waitreq_ff <= 1'b0;
        unique case (avs_address)
          REG_BUS_CTRL: readdata_ff <= {16'h0000, bus_control_reg_ff};
          REG_WAIT_FIRST: readdata_ff <= {16'h0000, wait_control_first_ff};
          REG_WAIT_SECOND: readdata_ff <= {16'h0000, wait_control_second_ff};
          REG_WAIT_THIRD: readdata_ff <= {16'h0000, wait_control_third_ff};
          REG_DRAM_CTRL: readdata_ff <= {16'h0000, dram_ctrl_reg_ff};
          REG_STATUS: readdata_ff <= {28'h0000000, area_ff, state_ff == ST_RUN};
          default: readdata_ff <= 32'h00000000;
        endcase
      end else begin
        waitreq_ff <= 1'b1;
      end
    end
  end

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_control_reg_ff <= RST_BUS_CTRL;
      wait_control_first_ff <= RST_WAIT_FIRST;
      wait_control_second_ff <= RST_WAIT_SECOND;
      wait_control_third_ff <= RST_WAIT_THIRD;
      dram_ctrl_reg_ff <= RST_DRAM_CTRL;
    end else if (clk_en && !waitreq_ff && avs_write) begin
      unique case (avs_address)
        REG_BUS_CTRL: bus_control_reg_ff <= merge16(bus_control_reg_ff, avs_writedata,
                                                     avs_byteenable);
        REG_WAIT_FIRST: wait_control_first_ff <= merge16(wait_control_first_ff, avs_writedata,
                                                         avs_byteenable);
        REG_WAIT_SECOND: wait_control_second_ff <= merge16(wait_control_second_ff,
                                                           avs_writedata, avs_byteenable);
        REG_WAIT_THIRD: wait_control_third_ff <= merge16(wait_control_third_ff, avs_writedata,
                                                         avs_byteenable);
        REG_DRAM_CTRL: dram_ctrl_reg_ff <= merge16(dram_ctrl_reg_ff, avs_writedata,
                                                   avs_byteenable);
        default: ;
      endcase
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign req_ack = ack_ff;
  assign req_err = err_ff;
  assign pins = pins_ff;

  // State and wait counts seen only by the checks below
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_cnt_ff <= 4'h0;
      waits_ff <= 4'h0;
      total_ff <= 3'h0;
    end else if (clk_en) begin
      if (start) begin
        st_cnt_ff <= 4'h0;
        waits_ff <= 4'h0;
        total_ff <= nxt_left;
      end else if (end_state) begin
        st_cnt_ff <= st_cnt_ff + 4'h1;
        if (hold_wait) begin
          waits_ff <= waits_ff + 4'h1;
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || !clk_en);

  a_ext_decode: assert property (start && !space_ok |=> ack_ff && err_ff)
    else $error("on-chip space not refused");
  a_one_state: assert property (fin && !is_long_area(area_ff) && !pin_en_ff &&
    !dram_ff |-> st_cnt_ff == 4'h0) else $error("unwaited short cycle not one state");
  a_two_plus_wait: assert property (fin && !is_long_area(area_ff) && pin_en_ff &&
    !dram_ff |-> st_cnt_ff == 4'h1 + waits_ff)
    else $error("short cycle not two states plus waits");
  a_pin_hold: assert property (end_state && hold_wait |=> (left_ff == 3'h2) &&
    (state_ff == ST_RUN) ##0 (tick_ff == 5'h00)) else $error("wait pin low did not hold");
  a_long_nowait: assert property (fin && is_long_area(area_ff) && !pin_en_ff |->
    ({1'b0, total_ff} == st_cnt_ff + 4'h1) && (waits_ff == 4'h0))
    else $error("long wait count wrong");
  a_long_pinwait: assert property (fin && is_long_area(area_ff) && pin_en_ff |->
    {1'b0, total_ff} + waits_ff == st_cnt_ff + 4'h1) else $error("long cycle plus waits wrong");
  a_gov_select: assert property (start && space_ok && !dram_hit && !req.write |=>
    pin_en_ff == $past(gov_bit)) else $error("wrong wait register governs read");
  a_write_pin: assert property (start && space_ok && !dram_hit && req.write &&
    (req.kind != KIND_DMA_SINGLE) |=> pin_en_ff) else $error("write cycle ignores wait pin");
  a_write_long: assert property (start && space_ok && is_long_area(area_dec) &&
    req.write && (req.kind != KIND_DMA_SINGLE) |=> left_ff == $past(lw_cnt) + 3'h1)
    else $error("long write length wrong");
  a_rd_duty35: assert property ((state_ff == ST_RUN) && !dram_ff && !wr_ff && first_ff &&
    bus_control_reg_ff[BUSCTL_RD_DUTY] && (tick_ff == DUTY35_TICKS) |=> !pins_ff.rd_n)
    else $error("read strobe not low after 35 percent");
  a_rd_duty50: assert property ((state_ff == ST_RUN) && !dram_ff && !wr_ff && first_ff &&
    !bus_control_reg_ff[BUSCTL_RD_DUTY] && (tick_ff == DUTY35_TICKS) |=> pins_ff.rd_n)
    else $error("read strobe low too early at 50 percent");
  a_cs_whole: assert property ((state_ff == ST_RUN) && !dram_ff |=>
    !pins_ff.cs_n[area_ff]) else $error("chip select dropped mid cycle");
  a_dram_no_cs: assert property ((state_ff == ST_RUN) && dram_ff |=> &pins_ff.cs_n)
    else $error("chip select in DRAM space");
  a_byte_sel: assert property ((state_ff == ST_RUN) && !dram_ff && bus16_ff &&
    bus_control_reg_ff[BUSCTL_BYTE_SEL] |=> (pins_ff.a0_upper == !$past(be_ff[1])) &&
    (pins_ff.lo_store_n == !$past(wr_ff))) else $error("byte select scheme wrong");
  a_byte_8bit: assert property ((state_ff == ST_RUN) && !dram_ff && !bus16_ff |=>
    pins_ff.hi_store_n && (pins_ff.a0_upper == $past(addr_ff[0])))
    else $error("8-bit space pins wrong");
  a_row_shift8: assert property ((state_ff == ST_RUN) && dram_ff && first_ff &&
    dram_ctrl_reg_ff[DRAMCTL_MUX_EN] && (dram_ctrl_reg_ff[2:1] == SHIFT8) |=>
    pins_ff.addr[15:0] == $past(addr_ff[23:8])) else $error("8-bit row shift wrong");
  a_row_shift9: assert property ((state_ff == ST_RUN) && dram_ff && first_ff &&
    dram_ctrl_reg_ff[DRAMCTL_MUX_EN] && (dram_ctrl_reg_ff[2:1] == SHIFT9) |=>
    pins_ff.addr[14:0] == $past(addr_ff[23:9])) else $error("9-bit row shift wrong");

  c_pin_wait: cover property (fin && (waits_ff != 4'h0));
  c_refused: cover property (start && !space_ok);
  c_long_four: cover property (fin && (total_ff == 3'h5));
  c_dram_row: cover property ((state_ff == ST_RUN) && dram_ff && first_ff);
endmodule // embcc_ctrl

/* embcc_pkg.sv */
// Constants and carriers shared by the external memory bus cycle controller
package embcc_pkg;
  // Bus state length in clocks, so that the read strobe duty can be resolved
  localparam int STATE_TICKS = 20;
  localparam logic [4:0] TICK_LAST = 5'(STATE_TICKS - 1);
  localparam int DUTY35_PCT = 35;
  localparam int DUTY50_PCT = 50;
  localparam logic [4:0] DUTY35_TICKS = 5'(STATE_TICKS * DUTY35_PCT / 100);
  localparam logic [4:0] DUTY50_TICKS = 5'(STATE_TICKS * DUTY50_PCT / 100);

  // Register word indexes; byte address is four times the index
  localparam logic [2:0] REG_BUS_CTRL = 3'h0;
  localparam logic [2:0] REG_WAIT_FIRST = 3'h1;
  localparam logic [2:0] REG_WAIT_SECOND = 3'h2;
  localparam logic [2:0] REG_WAIT_THIRD = 3'h3;
  localparam logic [2:0] REG_DRAM_CTRL = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // Field positions
  localparam int BUSCTL_DRAM_EN = 15;
  localparam int BUSCTL_MUX_IO = 14;
  localparam int BUSCTL_RD_DUTY = 13;
  localparam int BUSCTL_BYTE_SEL = 12;
  localparam int WAIT_READ_LSB = 8;
  localparam int WAIT3_LOW_LSB = 0;
  localparam int WAIT3_SIX_LSB = 2;
  localparam int DRAMCTL_MUX_EN = 0;
  localparam int DRAMCTL_SHIFT_LSB = 1;

  // Values after reset
  localparam logic [15:0] RST_BUS_CTRL = 16'h0000;
  localparam logic [15:0] RST_WAIT_FIRST = 16'hffff;
  localparam logic [15:0] RST_WAIT_SECOND = 16'hffff;
  localparam logic [15:0] RST_WAIT_THIRD = 16'h000f;
  localparam logic [15:0] RST_DRAM_CTRL = 16'h0000;

  // Encodings
  localparam logic [2:0] MODE_EXT8 = 3'h0;
  localparam logic [2:0] MODE_EXT16 = 3'h1;
  localparam logic [1:0] KIND_CPU = 2'h0;
  localparam logic [1:0] KIND_DMA_DUAL = 2'h1;
  localparam logic [1:0] KIND_DMA_SINGLE = 2'h2;
  localparam logic [1:0] SHIFT8 = 2'h0;
  localparam logic [1:0] SHIFT9 = 2'h1;
  localparam logic [1:0] SHIFT10 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } embcc_state_t;

  typedef struct packed {
    logic [27:0] addr;
    logic write;
    logic [1:0] be;
    logic [1:0] kind;
  } embcc_req_t;

  typedef struct packed {
    logic [7:0] cs_n;
    logic rd_n;
    logic hi_store_n;
    logic lo_store_n;
    logic a0_upper;
    logic [21:0] addr;
  } embcc_pins_t;

  localparam embcc_pins_t PINS_IDLE = '{cs_n: 8'hff, rd_n: 1'b1, hi_store_n: 1'b1,
                                         lo_store_n: 1'b1, a0_upper: 1'b1, addr: 22'h000000};
endpackage

/* embcc_sync2.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module embcc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First flop feeds only the second one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // embcc_sync2

/* embcc_addr_mux.sv */
// Row and column address multiplexer for the DRAM area
`timescale 1ns/10ps
module embcc_addr_mux (
  input wire logic [23:0] addr,
  input wire logic mux_en,
  input wire logic [1:0] shift,
  input wire logic row_phase,
  output logic [21:0] pin_addr
);
  import embcc_pkg::*;

  // Row bits above the shifted window are undefined; driven low here
  always_comb begin
    pin_addr = addr[21:0];
    if (mux_en && row_phase) begin
      unique case (shift)
        SHIFT9: pin_addr = {7'h00, addr[23:9]};
        SHIFT10: pin_addr = {8'h00, addr[23:10]};
        default: pin_addr = {6'h00, addr[23:8]};
      endcase
    end
  end
endmodule // embcc_addr_mux

/* embcc_sram_model.sv */
// Far-side memory model that stretches bus cycles through the wait pin
`timescale 1ns/10ps
module embcc_sram_model (
  input wire logic clock,
  input wire logic [7:0] cs_n,
  input wire logic [7:0] hold_clks,
  output logic wait_n_pin
);
  logic [7:0] busy_ff;
  // Clocks since a chip select fell; parks at zero between cycles
  always_ff @(posedge clock) begin
    if (&cs_n) busy_ff <= 8'h00;
    else if (busy_ff != 8'hff) busy_ff <= busy_ff + 8'h01;
  end
  // wait request
  // Pulled up when idle; low for the first hold_clks clocks of a cycle
  assign wait_n_pin = (&cs_n) | (busy_ff >= hold_clks);
endmodule // embcc_sram_model

/* embcc_ctrl_tb.sv */
// Self-checking bench for the external bus cycle controller
`timescale 1ns/10ps
module embcc_ctrl_tb;
  import embcc_pkg::*;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, req_valid;
  logic wait_n_pin, req_ack, req_err, e;
  logic [2:0] avs_address, mode_select_pins;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [7:0] hold_clks;
  embcc_req_t req;
  embcc_pins_t pins, snap;
  int bad_count, cmp_count, n;
  embcc_ctrl embcc_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req(req),
    .req_ack(req_ack), .req_err(req_err), .mode_select_pins(mode_select_pins),
    .wait_n_pin(wait_n_pin), .pins(pins));
  embcc_sram_model embcc_sram_model_inst (.clock(clock), .cs_n(pins.cs_n),
    .hold_clks(hold_clks), .wait_n_pin(wait_n_pin));
  // 8 ns system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Register access held until waitrequest is sampled low
  task bus(input logic wr, input logic [2:0] idx, input logic [15:0] wd);
    avs_address <= idx;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  // Request held to ack; n is edges from raise to ack, snap is mid first state
  task cyc(input logic [27:0] a, input logic wr, input logic [1:0] be,
           input logic [1:0] kd, input logic [7:0] hold);
    hold_clks <= hold;
    req <= '{addr: a, write: wr, be: be, kind: kd};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n == 11) snap = pins;
    end while (req_ack !== 1'b1);
    e = req_err;
    req_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // Reset value of the third wait register and an unmapped index
  task t_regs;
    bus(1'b0, REG_WAIT_THIRD, 16'h0000);
    check("third", d, 32'hf);
    bus(1'b1, 3'h6, 16'h5a5a);
    bus(1'b0, 3'h6, 16'h0000);
    check("unmapped", d, 32'h0);
  endtask
  // Short area: pin ignored with bit clear, waits with bit set, governing register
  task t_short;
    // all cycles here use area 4, whose wait bit is bit 12 of the first and second wait registers
    bus(1'b1, REG_WAIT_FIRST, 16'hefff);
    cyc(28'hc000000, 1'b0, 2'h3, KIND_CPU, 8'h1e);
    check("len1", n, 32'h16);
    check("cs", snap.cs_n, 32'hef);
    check("duty50", snap.rd_n, 32'h1);
    bus(1'b1, REG_WAIT_FIRST, 16'hffff);
    bus(1'b1, REG_WAIT_SECOND, 16'hefff);
    bus(1'b1, REG_BUS_CTRL, 16'h2000);
    cyc(28'hc000000, 1'b0, 2'h3, KIND_DMA_DUAL, 8'h1e);
    check("len2w", n, 32'h3e);
    check("duty35", snap.rd_n, 32'h0);
    cyc(28'hc000000, 1'b0, 2'h3, KIND_DMA_SINGLE, 8'h1e);
    check("single", n, 32'h16);
  endtask
  // Write length and byte-lane strobe schemes
  task t_bytes;
    bus(1'b1, REG_WAIT_FIRST, 16'hefff);
    bus(1'b1, REG_BUS_CTRL, 16'h0000);
    cyc(28'hc000000, 1'b1, 2'h2, KIND_CPU, 8'h00);
    check("wlen", n, 32'h2a);
    check("store", {snap.hi_store_n, snap.lo_store_n}, 32'h1);
    bus(1'b1, REG_BUS_CTRL, 16'h1000);
    cyc(28'hc000000, 1'b1, 2'h2, KIND_CPU, 8'h00);
    check("sel", {snap.hi_store_n, snap.lo_store_n, snap.a0_upper}, 32'h4);
    bus(1'b1, REG_BUS_CTRL, 16'h5000);
    cyc(28'h6004000, 1'b1, 2'h2, KIND_CPU, 8'h00);
    check("selio", {snap.hi_store_n, snap.lo_store_n, snap.a0_upper}, 32'h4);
    cyc(28'h4000001, 1'b1, 2'h1, KIND_CPU, 8'h00);
    check("b8", {snap.a0_upper, snap.lo_store_n}, 32'h2);
  endtask
  // Long-wait areas with both count fields
  task t_long;
    bus(1'b1, REG_BUS_CTRL, 16'h0000);
    bus(1'b1, REG_WAIT_THIRD, 16'h0003);
    bus(1'b1, REG_WAIT_FIRST, 16'hbbff);
    cyc(28'h2000000, 1'b0, 2'h3, KIND_CPU, 8'h5a);
    check("lw4", n, 32'h66);
    cyc(28'h6000000, 1'b0, 2'h3, KIND_CPU, 8'h5a);
    check("lw1", n, 32'h2a);
    cyc(28'h2000000, 1'b1, 2'h3, KIND_CPU, 8'h5a);
    check("lwpin", n, 32'h7a);
  endtask
  // Space decode: refusals and accepted edge cases
  task t_space;
    cyc(28'h5000000, 1'b0, 2'h3, KIND_CPU, 8'h00);
    check("a5", {e, n[7:0]}, 32'h102);
    cyc(28'hf000000, 1'b0, 2'h3, KIND_CPU, 8'h00);
    check("a7", {e, n[7:0]}, 32'h102);
    cyc(28'h7000000, 1'b0, 2'h3, KIND_CPU, 8'h00);
    check("a7ok", {e, n[7:0]}, 32'h2a);
    mode_select_pins <= 3'h2;
    repeat (4) @(posedge clock);
    cyc(28'h0000000, 1'b0, 2'h3, KIND_CPU, 8'h00);
    check("a0rom", {e, n[7:0]}, 32'h102);
  endtask
  // DRAM area: no chip select, row address per shift
  task t_dram;
    bus(1'b1, REG_BUS_CTRL, 16'h8000);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, REG_DRAM_CTRL, {13'h0000, 2'(k), 1'b1});
      cyc(28'h1abcdef, 1'b0, 2'h3, KIND_CPU, 8'h00);
      check("dcs", snap.cs_n, 32'hff);
      check("row", snap.addr, 32'(24'habcdef >> (8 + k)));
    end
  endtask
  // Reset, scenarios, verdict
  initial begin
    {sys_rst, avs_read, avs_write, req_valid} = 4'h8;
    {avs_address, avs_writedata, mode_select_pins, hold_clks, req} = '0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_regs;
    t_short;
    t_bytes;
    t_long;
    t_space;
    t_dram;
    finish_test;
  end
  // Hang guard, far beyond the fewer than a thousand cycles needed
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
endmodule // embcc_ctrl_tb
